/* dopc_defs.vh */
// register map and constants for the drive output port control block
`ifndef DOPC_DEFS_VH
`define DOPC_DEFS_VH
`define DOPC_ADDR_W        6
`define DOPC_OFS_OUT_A     6'h00
`define DOPC_OFS_OUT_B     6'h01
`define DOPC_OFS_OUT_C     6'h02
`define DOPC_OFS_CHG_A     6'h03
`define DOPC_OFS_CHG_B     6'h04
`define DOPC_OFS_CHG_C     6'h05
`define DOPC_OFS_LVL_A     6'h06
`define DOPC_OFS_LVL_B     6'h07
`define DOPC_OFS_LVL_C     6'h08
`define DOPC_OFS_FLAGS     6'h09
`define DOPC_OFS_MON_SEL   6'h0A
`define DOPC_OFS_MON_VAL   6'h0B
`define DOPC_OFS_STAT      6'h0C
`define DOPC_F_INPOS_REL   0
`define DOPC_F_PWM_EN      1
`define DOPC_F_CMD_RAMP    2
`define DOPC_F_MON_RAMP    3
`define DOPC_F_READY       4
`define DOPC_F_RUN         5
`define DOPC_F_HOME        6
`define DOPC_F_FAULT       7
`define DOPC_F_FAULT_DIS   8
`define DOPC_FLAGS_W       9
`define DOPC_FLAGS_RST     9'h000
`define DOPC_MON_SEL_NONE  8'h00
`define DOPC_CONV_W        16
`define DOPC_RAMP_MIN      16'h8000
`define DOPC_RAMP_MAX      16'h7FFF
`endif

/* dopc_loads.sv */
// pwm meter standing in for the velocity monitor load
`timescale 1ns/1ps
module dopc_loads (
    input  wire       i_clock,
    input  wire       i_pwm,
    output reg  [8:0] o_high_cnt = 9'h000
);
    reg [7:0] n_r   = 8'h00;
    reg [8:0] acc_r = 9'h000;
    always @(posedge i_clock) begin
        n_r <= n_r + 8'h01;
        acc_r <= (n_r == 8'hFF) ? 9'h000 : acc_r + i_pwm;
        if (n_r == 8'hFF)
            o_high_cnt <= acc_r + i_pwm;
    end
endmodule // dopc_loads

/* dopc_monitor.sv */
// port assertions for the drive output port control block
`timescale 1ns/1ps
module dopc_monitor (
    input wire        i_clock,
    input wire        i_rst,
    input wire [5:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest,
    input wire        i_prog_end,
    input wire [23:0] o_outputs,
    input wire        i_ready,
    input wire        o_ready_relay,
    input wire        i_prog_running,
    input wire        o_prog_running_out,
    input wire        i_fault,
    input wire        i_drive_disabled,
    input wire        o_fault_out
);
    // accepted write, and a read in its first cycle
    wire take = i_avs_write && !o_avs_waitrequest;
    wire rd0  = i_avs_read && o_avs_waitrequest;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_outs_hold_still: assert property (
        !i_prog_end && !(take && i_avs_address < 6'h03) |=> $stable(o_outputs))
        else $error("outputs moved without cause");
    chk_write_byte_a: assert property (
        take && i_avs_address == 6'h00 && !i_prog_end
        |=> o_outputs[7:0] == $past(i_avs_writedata[7:0])) else $error("byte a write lost");
    chk_write_byte_b: assert property (
        take && i_avs_address == 6'h01 && !i_prog_end
        |=> o_outputs[15:8] == $past(i_avs_writedata[7:0])) else $error("byte b write lost");
    chk_wait_one_cycle: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest held too long");
    chk_status_mirror: assert property (
        rd0 && i_avs_address == 6'h0C |=> o_avs_readdata == {24'h0, $past(o_outputs[7:0])})
        else $error("status byte wrong");
    chk_mon_value_hidden: assert property (
        rd0 && i_avs_address == 6'h0B |=> o_avs_readdata == 32'h0)
        else $error("monitor value readable");
    chk_relay_needs_ready: assert property (
        !i_ready |=> !o_ready_relay) else $error("relay on without ready");
    chk_run_needs_input: assert property (
        !i_prog_running |=> !o_prog_running_out) else $error("run output without program");
    chk_fault_needs_cause: assert property (
        !i_fault && !i_drive_disabled |=> !o_fault_out) else $error("fault output without cause");
endmodule // dopc_monitor

/* dopc_pwm8.v */
// 8-bit pwm generator for the velocity monitor
`timescale 1ns/1ps
module dopc_pwm8 (
    input  wire       i_clock,
    input  wire       i_rst,
    input  wire       i_en,
    input  wire [7:0] i_duty,
    output reg        o_pwm
);
    reg [7:0] cnt_r;
    reg [7:0] duty_r;

    // duty latched at period start so a change never makes a runt pulse
    always @(posedge i_clock) begin
        if (i_rst) begin
            cnt_r  <= 8'h00;
            duty_r <= 8'h00;
            o_pwm  <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == 8'hFF)
                duty_r <= i_duty;
            o_pwm <= i_en && (cnt_r < duty_r);
        end
    end
endmodule // dopc_pwm8

/* dopc_top.v */
// drive output port control: outputs, end masks, monitor and flags
`timescale 1ns/1ps
`include "dopc_defs.vh"
module dopc_top (
    // clock, reset and avalon-mm slave
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire [5:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    // drive-side status and data
    input  wire        i_prog_end,
    input  wire        i_expansion_present,
    input  wire [15:0] i_monitor_var,
    input  wire [7:0]  i_feedback_velocity,
    input  wire        i_drive_disabled,
    input  wire        i_fault,
    input  wire        i_at_home,
    input  wire        i_prog_running,
    input  wire        i_ready,
    input  wire [15:0] i_command_value,
    // outputs to loads and converters
    output reg  [23:0] o_outputs,
    output wire        o_inpos_relative_sel,
    output reg  [15:0] o_monitor_analog_out,
    output reg  [15:0] o_command_converter,
    output wire        o_velocity_pwm,
    output reg         o_ready_relay,
    output reg         o_prog_running_out,
    output reg         o_home_reached_out,
    output reg         o_fault_out
);
    reg  [23:0] end_change_mask_r;
    reg  [23:0] end_level_mask_r;
    reg  [8:0]  flags_r;
    reg  [7:0]  monitor_source_sel_r;
    reg  [15:0] monitor_conv_value_r;
    reg  [15:0] mon_ramp_r;
    reg  [15:0] cmd_ramp_r;
    reg         ack_r;
    // synchronised expansion card detect
    reg         exp_meta_r;
    reg         exp_sync_r;
    reg  [23:0] out_nxt;
    wire        acc;
    wire        wr_ok;

    // one wait cycle per access keeps read data registered
    assign acc               = (i_avs_read || i_avs_write) && !ack_r;
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
    assign wr_ok             = i_avs_write && ack_r;

    // in-position mode, 1 = relative, 0 = absolute
    assign o_inpos_relative_sel = flags_r[`DOPC_F_INPOS_REL];

    // byte lane for an indexed 24-bit set
    function [7:0] byte_of;
        input [23:0] v;
        input [1:0]  k;
        begin
            case (k)
                2'h0:    byte_of = v[7:0];
                2'h1:    byte_of = v[15:8];
                default: byte_of = v[23:16];
            endcase
        end
    endfunction

    // ramp step that wraps from top to bottom of the full span
    // wrap rather than saturate so the sweep runs continually
    function [15:0] ramp_step;
        input [15:0] v;
        begin
            ramp_step = (v == `DOPC_RAMP_MAX) ? `DOPC_RAMP_MIN : v + 16'h0001;
        end
    endfunction

    // next output state from writes and program end
    always @* begin
        out_nxt = o_outputs;
        if (wr_ok && i_avs_address == `DOPC_OFS_OUT_A)
            out_nxt[7:0] = i_avs_writedata[7:0];
        if (wr_ok && i_avs_address == `DOPC_OFS_OUT_B)
            out_nxt[15:8] = i_avs_writedata[7:0];
        if (wr_ok && i_avs_address == `DOPC_OFS_OUT_C)
            out_nxt[23:16] = i_avs_writedata[7:0];
        // a same-cycle bus write lands first so the mask still wins
        // masked end update
        if (i_prog_end)
            out_nxt = (out_nxt & ~end_change_mask_r)
                    | (end_change_mask_r & end_level_mask_r);
    end

    // control registers
    always @(posedge i_clock) begin
        if (i_rst) begin
            ack_r                <= 1'b0;
            o_outputs            <= 24'h000000;
            end_change_mask_r    <= 24'h000000;
            end_level_mask_r     <= 24'h000000;
            flags_r              <= `DOPC_FLAGS_RST;
            monitor_source_sel_r <= `DOPC_MON_SEL_NONE;
            monitor_conv_value_r <= 16'h0000;
        end else begin
            ack_r     <= acc;
            o_outputs <= out_nxt;
            if (wr_ok) begin
                case (i_avs_address)
                    `DOPC_OFS_CHG_A: end_change_mask_r[7:0]   <= i_avs_writedata[7:0];
                    `DOPC_OFS_CHG_B: end_change_mask_r[15:8]  <= i_avs_writedata[7:0];
                    `DOPC_OFS_CHG_C: end_change_mask_r[23:16] <= i_avs_writedata[7:0];
                    `DOPC_OFS_LVL_A: end_level_mask_r[7:0]    <= i_avs_writedata[7:0];
                    `DOPC_OFS_LVL_B: end_level_mask_r[15:8]   <= i_avs_writedata[7:0];
                    `DOPC_OFS_LVL_C: end_level_mask_r[23:16]  <= i_avs_writedata[7:0];
                    `DOPC_OFS_FLAGS: flags_r <= i_avs_writedata[8:0];
                    `DOPC_OFS_MON_SEL: monitor_source_sel_r <= i_avs_writedata[7:0];
                    `DOPC_OFS_MON_VAL: monitor_conv_value_r <= i_avs_writedata[15:0];
                    // unmapped offsets fall through: writes there are dropped
                    default: ;
                endcase
            end
        end
    end

    // two-flop synchroniser: the card detect is a board pin, not on this clock
    always @(posedge i_clock) begin
        if (i_rst) begin
            exp_meta_r <= 1'b0;
            exp_sync_r <= 1'b0;
        end else begin
            exp_meta_r <= i_expansion_present;
            exp_sync_r <= exp_meta_r;
        end
    end

    // read mux, registered on the wait cycle
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read && !ack_r) begin
            case (i_avs_address)
                `DOPC_OFS_OUT_A, `DOPC_OFS_STAT:
                    o_avs_readdata <= {24'h000000, byte_of(o_outputs, 2'h0)};
                // expansion bytes read zero until the detect has settled
                `DOPC_OFS_OUT_B:
                    o_avs_readdata <= {24'h000000, exp_sync_r ?
                                       byte_of(o_outputs, 2'h1) : 8'h00};
                `DOPC_OFS_OUT_C:
                    o_avs_readdata <= {24'h000000, exp_sync_r ?
                                       byte_of(o_outputs, 2'h2) : 8'h00};
                `DOPC_OFS_CHG_A: o_avs_readdata <= {24'h000000, byte_of(end_change_mask_r, 2'h0)};
                `DOPC_OFS_CHG_B: o_avs_readdata <= {24'h000000, byte_of(end_change_mask_r, 2'h1)};
                `DOPC_OFS_CHG_C: o_avs_readdata <= {24'h000000, byte_of(end_change_mask_r, 2'h2)};
                `DOPC_OFS_LVL_A: o_avs_readdata <= {24'h000000, byte_of(end_level_mask_r, 2'h0)};
                `DOPC_OFS_LVL_B: o_avs_readdata <= {24'h000000, byte_of(end_level_mask_r, 2'h1)};
                `DOPC_OFS_LVL_C: o_avs_readdata <= {24'h000000, byte_of(end_level_mask_r, 2'h2)};
                `DOPC_OFS_FLAGS: o_avs_readdata <= {23'h0, flags_r};
                `DOPC_OFS_MON_SEL: o_avs_readdata <= {24'h000000, monitor_source_sel_r};
                default: o_avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // converters: monitor ramp beats selected variable beats direct value; command ramp beats command input
    always @(posedge i_clock) begin
        if (i_rst) begin
            mon_ramp_r           <= `DOPC_RAMP_MIN;
            cmd_ramp_r           <= `DOPC_RAMP_MIN;
            o_monitor_analog_out <= 16'h0000;
            o_command_converter  <= 16'h0000;
        end else begin
            // a ramp restarts at the bottom whenever its flag drops
            // diagnostic ramps full span
            mon_ramp_r <= flags_r[`DOPC_F_MON_RAMP] ? ramp_step(mon_ramp_r) : `DOPC_RAMP_MIN;
            cmd_ramp_r <= flags_r[`DOPC_F_CMD_RAMP] ? ramp_step(cmd_ramp_r) : `DOPC_RAMP_MIN;
            if (flags_r[`DOPC_F_MON_RAMP])
                o_monitor_analog_out <= mon_ramp_r;
            else if (monitor_source_sel_r != `DOPC_MON_SEL_NONE)
                o_monitor_analog_out <= i_monitor_var;
            else
                o_monitor_analog_out <= monitor_conv_value_r;
            o_command_converter <= flags_r[`DOPC_F_CMD_RAMP] ? cmd_ramp_r : i_command_value;
        end
    end

    // status outputs gated by their enables
    // no synchroniser here: these levels come from the drive's own clocked logic
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_ready_relay      <= 1'b0;
            o_prog_running_out <= 1'b0;
            o_home_reached_out <= 1'b0;
            o_fault_out        <= 1'b0;
        end else begin
            o_ready_relay      <= flags_r[`DOPC_F_READY] && i_ready;
            o_prog_running_out <= flags_r[`DOPC_F_RUN] && i_prog_running;
            o_home_reached_out <= flags_r[`DOPC_F_HOME] && i_at_home;
            o_fault_out        <= flags_r[`DOPC_F_FAULT] && (i_fault ||
                                  (flags_r[`DOPC_F_FAULT_DIS] && i_drive_disabled));
        end
    end

    // pwm counter runs free; the enable only gates its output
    // velocity pwm monitor
    dopc_pwm8 u_pwm (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_en    (flags_r[`DOPC_F_PWM_EN]),
        .i_duty  (i_feedback_velocity),
        .o_pwm   (o_velocity_pwm)
    );
endmodule // dopc_top

/* drive_output_port_control_test.sv */
// self-checking bench for the drive output port control block
`timescale 1ns/1ps
module drive_output_port_control_test;
    logic        i_clock = 0, i_rst = 1, i_avs_read = 0, i_avs_write = 0, i_prog_end = 0;
    logic        i_expansion_present = 0, i_drive_disabled = 0, i_fault = 0;
    logic        i_at_home = 0, i_prog_running = 0, i_ready = 0;
    logic [5:0]  i_avs_address = '0;
    logic [7:0]  i_feedback_velocity = '0;
    logic [15:0] i_monitor_var = '0, i_command_value = 16'h2222;
    logic [31:0] i_avs_writedata = '0, o_avs_readdata, q, v;
    logic [23:0] o_outputs;
    logic [15:0] o_monitor_analog_out, o_command_converter;
    logic [8:0]  high_cnt;
    logic        o_avs_waitrequest, o_inpos_relative_sel, o_velocity_pwm, o_ready_relay;
    logic        o_prog_running_out, o_home_reached_out, o_fault_out;
    int          fails = 0, checks = 0;
    dopc_top DUT (.i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .o_avs_readdata, .o_avs_waitrequest, .i_prog_end, .i_expansion_present, .i_monitor_var,
        .i_feedback_velocity, .i_drive_disabled, .i_fault, .i_at_home, .i_prog_running, .i_ready,
        .i_command_value, .o_outputs, .o_inpos_relative_sel, .o_monitor_analog_out,
        .o_command_converter, .o_velocity_pwm, .o_ready_relay, .o_prog_running_out,
        .o_home_reached_out, .o_fault_out);
    dopc_loads LOAD (.i_clock, .i_pwm(o_velocity_pwm), .o_high_cnt(high_cnt));
    // clock and hang guard
    initial forever #10 i_clock = ~i_clock;
    initial begin
        #400000;
        fails++;
        finish_test;
    end
    task finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one transfer; held until waitrequest is sampled low at a rising edge,
    // read data taken at that same edge, released only after it
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clock);
        {i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, !w, a, d};
        do
            @(posedge i_clock);
        while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        {i_avs_write, i_avs_read} <= 2'h0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        bus(0, a, 0);
        chk($sformatf("read %h", a), e, q);
    endtask
    task look;
        @(posedge i_clock);
        @(negedge i_clock);
    endtask
    task t_regs;
        rd(6'h09, 32'h0);
        bus(1, 6'h00, 32'hFFFFFFA5);
        rd(6'h00, 32'hA5);
        rd(6'h0C, 32'hA5);
        bus(1, 6'h01, 32'h3C);
        rd(6'h01, 32'h0);
        i_expansion_present <= 1'h1;
        // card detect passes a two-flop synchroniser first
        repeat (2) @(posedge i_clock);
        rd(6'h01, 32'h3C);
        bus(1, 6'h0B, 32'h55);
        rd(6'h0B, 32'h0);
        bus(1, 6'h3F, 32'h77);
        rd(6'h3F, 32'h0);
    endtask
    // change mask picks bits, level mask sets them, all in one edge
    task t_end;
        bus(1, 6'h03, 32'h0F);
        bus(1, 6'h06, 32'h0A);
        bus(1, 6'h05, 32'h81);
        bus(1, 6'h08, 32'h01);
        bus(1, 6'h02, 32'h80);
        rd(6'h08, 32'h01);
        i_prog_end <= 1'h1;
        @(negedge i_clock);
        chk("outs before", 32'h803CA5, o_outputs);
        @(posedge i_clock);
        i_prog_end <= 1'h0;
        @(negedge i_clock);
        chk("outs after", 32'h013CAA, o_outputs);
    endtask
    task t_flags;
        {i_ready, i_prog_running, i_at_home, i_drive_disabled} <= 4'hF;
        bus(1, 6'h09, 32'h1F1);
        look;
        v = {o_ready_relay, o_prog_running_out, o_home_reached_out, o_fault_out};
        chk("status", 32'h1F, {v[3:0], o_inpos_relative_sel});
        rd(6'h09, 32'h1F1);
        i_drive_disabled <= 1'h0;
        look;
        chk("fault off", 32'h0, o_fault_out);
        bus(1, 6'h09, 32'h0);
        look;
        chk("all off", 32'h0, {o_ready_relay, o_prog_running_out, o_home_reached_out});
    endtask
    task t_mon;
        bus(1, 6'h0B, 32'h1234);
        look;
        chk("mon direct", 32'h1234, o_monitor_analog_out);
        i_monitor_var <= 16'hBEEF;
        bus(1, 6'h0A, 32'h01);
        look;
        chk("mon source", 32'hBEEF, o_monitor_analog_out);
        rd(6'h0A, 32'h01);
        bus(1, 6'h0B, 32'h4321);
        look;
        chk("mon kept", 32'hBEEF, o_monitor_analog_out);
        bus(1, 6'h0A, 32'h00);
        bus(1, 6'h09, 32'h0C);
        look;
        v = {o_monitor_analog_out, o_command_converter};
        look;
        chk("ramps", v + 32'h00010001, {o_monitor_analog_out, o_command_converter});
        bus(1, 6'h09, 32'h0);
        look;
        chk("cmd normal", 32'h2222, o_command_converter);
    endtask
    task t_pwm;
        i_feedback_velocity <= 8'h40;
        bus(1, 6'h09, 32'h02);
        // up to one pwm period for the duty latch, then a whole meter frame
        repeat (800) @(posedge i_clock);
        @(negedge i_clock);
        chk("pwm duty", 32'h40, high_cnt);
        bus(1, 6'h09, 32'h0);
        repeat (800) @(posedge i_clock);
        @(negedge i_clock);
        chk("pwm off", 32'h0, high_cnt);
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'h0;
        t_regs;
        t_end;
        t_flags;
        t_mon;
        t_pwm;
        finish_test;
    end
endmodule // drive_output_port_control_test
bind dopc_top dopc_monitor MON (.i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_prog_end, .o_outputs, .i_ready,
    .o_ready_relay, .i_prog_running, .o_prog_running_out, .i_fault, .i_drive_disabled,
    .o_fault_out);
